//--- cdm_defines.vh
// Function
// - After demand drops and the compressor stops, the contactor drive stays open until three minutes have passed.
// - The contactor contact is closed while powered unless the delay, a lockout or a cutout blocks it.
// - The green lamp is lit whenever control power is sensed at the supply inputs.
// - An active alert pulses the yellow lamp its code count, pauses, and repeats while it lasts.
// - A non-latching alert clears itself and operation resumes once its cause is gone.
// - A latching alert persists until main power is cycled, which alone restores the initial state.
// - The red lamp blinks while the anti-recycle delay runs and is steady during a lockout.
// - Demand present with no power on any of the three line leads enters lockout.
// - Trip lockout stays latched with a steady red lamp and an open contact until power is cycled.
// - Low control power blinks the yellow and red lamps together.
// - The anti-recycle delay restarts every time demand drops and the compressor stops, except after a fourth consecutive short run, which locks out instead.
// - Demand arriving during the delay keeps the contact open until the delay ends.
// - Four consecutive runs each shorter than three minutes give a lockout shown by three pulses.
`ifndef CDM_DEFINES_VH
`define CDM_DEFINES_VH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CDM_CLK_MHZ         100
`define CDM_TICK_US         1000
`define CDM_TICK_CYCLES     (`CDM_TICK_US * `CDM_CLK_MHZ)
`define CDM_RECYCLE_MIN     3
`define CDM_MS_PER_MIN      60000
`define CDM_RECYCLE_MS      (`CDM_RECYCLE_MIN * `CDM_MS_PER_MIN)
`define CDM_TRIP_QUAL_MS    500
`define CDM_SHORT_RUNS      4
`define CDM_PULSE_ON_MS     250
`define CDM_PULSE_OFF_MS    250
`define CDM_PAUSE_MS        2000
`define CDM_BLINK_HALF_MS   500

// ----------------------------------------------------------------------------
// Alert codes
// ----------------------------------------------------------------------------
`define CDM_CODE_NONE       3'h0
`define CDM_CODE_PRESSURE   3'h2
`define CDM_CODE_SHORT      3'h3

`endif

//--- cdm_lamp_blink.v
`timescale 1ns/1ps
`include "cdm_defines.vh"

module cdm_lamp_blink #(
  parameter ON_MS    = `CDM_PULSE_ON_MS,
  parameter OFF_MS   = `CDM_PULSE_OFF_MS,
  parameter PAUSE_MS = `CDM_PAUSE_MS
) (
  input  wire       mclk,
  input  wire       srst,
  input  wire       tick,
  input  wire [2:0] code,
  output reg        lampOn
);

  // --------------------------------------------------------------------------
  // Pulse sequencer
  // --------------------------------------------------------------------------
  localparam [1:0] BL_IDLE  = 2'h0;
  localparam [1:0] BL_ON    = 2'h1;
  localparam [1:0] BL_GAP   = 2'h2;
  localparam [1:0] BL_PAUSE = 2'h3;

  reg [1:0]  state;
  reg [2:0]  pulseNum;
  reg [31:0] timer;

  always @(posedge mclk)
  begin
    if (srst)
    begin
      state    <= BL_IDLE;
      pulseNum <= 3'h0;
      timer    <= 32'h0;
      lampOn   <= 1'b0;
    end
    else if (code == `CDM_CODE_NONE)
    begin
      // A cleared code stops the lamp at once rather than finishing the group.
      state    <= BL_IDLE;
      pulseNum <= 3'h0;
      timer    <= 32'h0;
      lampOn   <= 1'b0;
    end
    else
    begin
      case (state)
        BL_IDLE:
        begin
          state    <= BL_ON;
          pulseNum <= 3'h1;
          timer    <= 32'h0;
          lampOn   <= 1'b1;
        end
        BL_ON:
          if (tick)
          begin
            if (timer == ON_MS - 1)
            begin
              timer  <= 32'h0;
              lampOn <= 1'b0;
              state  <= (pulseNum >= code) ? BL_PAUSE : BL_GAP;
            end
            else
              timer <= timer + 32'h1;
          end
        BL_GAP:
          if (tick)
          begin
            if (timer == OFF_MS - 1)
            begin
              timer    <= 32'h0;
              lampOn   <= 1'b1;
              pulseNum <= pulseNum + 3'h1;
              state    <= BL_ON;
            end
            else
              timer <= timer + 32'h1;
          end
        BL_PAUSE:
          if (tick)
          begin
            if (timer == PAUSE_MS - 1)
            begin
              timer <= 32'h0;
              state <= BL_IDLE;
            end
            else
              timer <= timer + 32'h1;
          end
        default:
        begin
          state  <= BL_IDLE;
          lampOn <= 1'b0;
        end
      endcase
    end
  end

endmodule

//--- cdm_monitor.v
`timescale 1ns/1ps
`include "cdm_defines.vh"

module cdm_monitor #(
  parameter TICK_CYCLES  = `CDM_TICK_CYCLES,
  parameter RECYCLE_MS   = `CDM_RECYCLE_MS,
  parameter TRIP_QUAL_MS = `CDM_TRIP_QUAL_MS,
  parameter SHORT_RUNS   = `CDM_SHORT_RUNS,
  parameter BLINK_MS     = `CDM_BLINK_HALF_MS,
  parameter ON_MS        = `CDM_PULSE_ON_MS,
  parameter OFF_MS       = `CDM_PULSE_OFF_MS,
  parameter PAUSE_MS     = `CDM_PAUSE_MS
) (
  input  wire mclk,
  input  wire srst,
  input  wire coolDemand,
  input  wire lineSenseA,
  input  wire lineSenseB,
  input  wire lineSenseC,
  input  wire lowPressureCutoutOpen,
  input  wire highPressureCutoutOpen,
  input  wire controlPowerPresent,
  input  wire controlPowerLow,
  output reg  contactorClosed,
  output reg  powerLamp,
  output reg  alertLamp,
  output reg  tripLamp
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  localparam NPIN = 8;

  wire [NPIN-1:0] pinRaw;
  reg  [NPIN-1:0] syncA;
  reg  [NPIN-1:0] syncB;
  reg  [NPIN-1:0] syncC;
  reg  [NPIN-1:0] pinStable;

  assign pinRaw = {controlPowerLow, controlPowerPresent, highPressureCutoutOpen,
                   lowPressureCutoutOpen, lineSenseC, lineSenseB, lineSenseA,
                   coolDemand};

  // Three stages per pin; the extra stage costs one cycle of latency but lets a
  // single-cycle glitch on a long field wire pass without being accepted.
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1)
    begin : gSync
      always @(posedge mclk)
      begin
        if (srst)
        begin
          syncA[gi]     <= 1'b0;
          syncB[gi]     <= 1'b0;
          syncC[gi]     <= 1'b0;
          pinStable[gi] <= 1'b0;
        end
        else
        begin
          syncA[gi] <= pinRaw[gi];
          syncB[gi] <= syncA[gi];
          syncC[gi] <= syncB[gi];
          // A pin change is accepted only when the last two stages agree.
          if (syncB[gi] == syncC[gi])
            pinStable[gi] <= syncC[gi];
        end
      end
    end
  endgenerate

  wire demand    = pinStable[0];
  wire lineOk    = pinStable[1] | pinStable[2] | pinStable[3];
  wire cutoutOpn = pinStable[4] | pinStable[5];
  wire powerOk   = pinStable[6];
  wire powerLow  = pinStable[7];

  // --------------------------------------------------------------------------
  // Millisecond time base
  // --------------------------------------------------------------------------
  // A one-cycle strobe every millisecond; every timer below counts these strobes,
  // so its length is only known to within one tick.
  reg [31:0] tickDiv;
  reg        tick;

  always @(posedge mclk)
  begin
    if (srst)
    begin
      tickDiv <= 32'h0;
      tick    <= 1'b0;
    end
    else if (tickDiv == TICK_CYCLES - 1)
    begin
      tickDiv <= 32'h0;
      tick    <= 1'b1;
    end
    else
    begin
      tickDiv <= tickDiv + 32'h1;
      tick    <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Compressor sequencing
  // --------------------------------------------------------------------------
  // ST_DELAY holds the contact open for the anti-recycle time, ST_IDLE waits for
  // demand, ST_RUN times the run and watches line power, ST_LOCK is terminal.
  localparam [1:0] ST_DELAY = 2'h0;
  localparam [1:0] ST_IDLE  = 2'h1;
  localparam [1:0] ST_RUN   = 2'h2;
  localparam [1:0] ST_LOCK  = 2'h3;

  reg [1:0]  state;
  reg [31:0] delayMs;
  reg [31:0] runMs;
  reg [31:0] noLineMs;
  reg [2:0]  shortRuns;
  reg        shortLock;

  wire [2:0] next_shortRuns = shortRuns + 3'h1;

  // Power-on reset is the only way out of ST_LOCK and the only clear.
  always @(posedge mclk)
  begin
    if (srst)
    begin
      state     <= ST_DELAY;
      delayMs   <= 32'h0;
      runMs     <= 32'h0;
      noLineMs  <= 32'h0;
      shortRuns <= 3'h0;
      shortLock <= 1'b0;
    end
    else
    begin
      case (state)
        ST_DELAY:
        begin
          // Demand seen here is simply held off until the delay has run out.
          // The first tick can land just after the stop, so one extra tick is
          // counted to keep the off interval at or above the full delay.
          if (tick)
          begin
            if (delayMs >= RECYCLE_MS)
              state <= ST_IDLE;
            else
              delayMs <= delayMs + 32'h1;
          end
        end
        ST_IDLE:
          if (demand && !cutoutOpn)
          begin
            state    <= ST_RUN;
            runMs    <= 32'h0;
            noLineMs <= 32'h0;
          end
        ST_RUN:
          if (!demand)
          begin
            state   <= ST_DELAY;
            delayMs <= 32'h0;
            if (runMs < RECYCLE_MS)
            begin
              shortRuns <= next_shortRuns;
              if (next_shortRuns >= SHORT_RUNS)
              begin
                state     <= ST_LOCK;
                shortLock <= 1'b1;
              end
            end
            else
              shortRuns <= 3'h0;
          end
          else
          begin
            if (tick && runMs < RECYCLE_MS)
              runMs <= runMs + 32'h1;
            // Only judge line power while our contact is actually closed,
            // so a cutout that opened the coil is not mistaken for a trip.
            if (cutoutOpn || lineOk)
              noLineMs <= 32'h0;
            else if (tick)
            begin
              if (noLineMs >= TRIP_QUAL_MS - 1)
                state <= ST_LOCK;
              else
                noLineMs <= noLineMs + 32'h1;
            end
          end
        ST_LOCK:
          state <= ST_LOCK;
        default:
          state <= ST_DELAY;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Alert code and lamps
  // --------------------------------------------------------------------------
  // The short-cycle code outranks the cutout code because it latches, while a
  // cutout code must vanish on its own once the switch closes again.
  reg [2:0] alertCode;

  always @*
  begin
    if (shortLock)
      alertCode = `CDM_CODE_SHORT;
    else if (cutoutOpn && state != ST_LOCK)
      alertCode = `CDM_CODE_PRESSURE;
    else
      alertCode = `CDM_CODE_NONE;
  end

  wire codeLamp;

  cdm_lamp_blink #(
    .ON_MS    (ON_MS),
    .OFF_MS   (OFF_MS),
    .PAUSE_MS (PAUSE_MS)
  ) uBlink (
    .mclk   (mclk),
    .srst   (srst),
    .tick   (tick),
    .code   (alertCode),
    .lampOn (codeLamp)
  );

  // One free-running square wave serves both the delay blink and the low-power
  // blink, so the two lamps stay in step without any extra alignment.
  reg [31:0] blinkMs;
  reg        blinkPhase;

  always @(posedge mclk)
  begin
    if (srst)
    begin
      blinkMs    <= 32'h0;
      blinkPhase <= 1'b0;
    end
    else if (tick)
    begin
      if (blinkMs == BLINK_MS - 1)
      begin
        blinkMs    <= 32'h0;
        blinkPhase <= ~blinkPhase;
      end
      else
        blinkMs <= blinkMs + 32'h1;
    end
  end

  // --------------------------------------------------------------------------
  // Output drive
  // --------------------------------------------------------------------------
  // The contact opens for the delay, a lockout or an open cutout; a cutout also
  // opens it in ST_RUN so that the coil never fights the pressure switch.
  wire contactAllowed = (state == ST_IDLE || state == ST_RUN) && !cutoutOpn;

  reg next_alertLamp;
  reg next_tripLamp;

  // Low control power takes both lamps over, since any code shown then could
  // be a symptom of the sagging supply rather than of the compressor.
  always @*
  begin
    if (powerLow)
    begin
      next_alertLamp = blinkPhase;
      next_tripLamp  = blinkPhase;
    end
    else
    begin
      next_alertLamp = codeLamp;
      if (state == ST_LOCK)
        next_tripLamp = 1'b1;
      else if (state == ST_DELAY)
        next_tripLamp = blinkPhase;
      else
        next_tripLamp = 1'b0;
    end
  end

  always @(posedge mclk)
  begin
    if (srst)
    begin
      contactorClosed <= 1'b0;
      powerLamp       <= 1'b0;
      alertLamp       <= 1'b0;
      tripLamp        <= 1'b0;
    end
    else
    begin
      contactorClosed <= contactAllowed;
      powerLamp       <= powerOk;
      alertLamp       <= next_alertLamp;
      tripLamp        <= next_tripLamp;
    end
  end

endmodule

//--- cdm_monitor_props.sv
`timescale 1ns/1ps
module cdm_monitor_chk #(
  parameter TICK_CYCLES = 10,
  parameter RECYCLE_MS  = 20,
  parameter BLINK_MS    = 2
) (
  input wire mclk,
  input wire srst,
  input wire coolDemand,
  input wire lineSenseA,
  input wire lineSenseB,
  input wire lineSenseC,
  input wire lowPressureCutoutOpen,
  input wire highPressureCutoutOpen,
  input wire controlPowerPresent,
  input wire controlPowerLow,
  input wire contactorClosed,
  input wire powerLamp,
  input wire alertLamp,
  input wire tripLamp
);
  localparam DLY = RECYCLE_MS * TICK_CYCLES;
  localparam HI  = 2 * BLINK_MS * TICK_CYCLES + 2;
  reg  [31:0] idleCnt;
  reg  [31:0] redCnt;
  wire        noLine = !(lineSenseA | lineSenseB | lineSenseC);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (srst);

  // A red lamp lit longer than a whole blink period can only mean a lockout.
  always @(posedge mclk)
  begin
    idleCnt <= (srst || coolDemand) ? 32'h0 : idleCnt + 32'h1;
    redCnt  <= (srst || !tripLamp) ? 32'h0 : redCnt + 32'h1;
  end

  chk_reset_quiet:
    assert property (disable iff (1'b0)
      srst |=> !(contactorClosed | powerLamp | alertLamp | tripLamp))
    else $error("output active after reset");
  chk_delay_min:
    assert property ($rose(contactorClosed) && !coolDemand |-> idleCnt >= DLY)
    else $error("contact closed before the delay ran out");
  chk_delay_blink:
    assert property ($fell(srst) |-> ##[1:30] tripLamp)
    else $error("red lamp not blinking during delay");
  chk_lock_held:
    assert property (redCnt > HI |-> tripLamp && !contactorClosed)
    else $error("lockout released");
  chk_trip_enter:
    assert property ((coolDemand && contactorClosed && noLine && !lowPressureCutoutOpen
      && !highPressureCutoutOpen)[*8] |-> ##[1:60] (tripLamp && !contactorClosed))
    else $error("no lockout on missing line power");
  chk_cutout_opens:
    assert property ((lowPressureCutoutOpen || highPressureCutoutOpen)[*8] |-> !contactorClosed)
    else $error("contact closed with cutout open");
  chk_green_lamp:
    assert property (controlPowerPresent[*8] |-> powerLamp)
    else $error("green lamp dark with power present");
  chk_low_unison:
    assert property (controlPowerLow[*8] |-> alertLamp == tripLamp)
    else $error("lamps not in unison on low power");
endmodule

bind cdm_monitor cdm_monitor_chk #(
  .TICK_CYCLES(TICK_CYCLES), .RECYCLE_MS(RECYCLE_MS), .BLINK_MS(BLINK_MS)
) u_chk (
  .mclk(mclk), .srst(srst), .coolDemand(coolDemand), .lineSenseA(lineSenseA),
  .lineSenseB(lineSenseB), .lineSenseC(lineSenseC),
  .lowPressureCutoutOpen(lowPressureCutoutOpen), .highPressureCutoutOpen(highPressureCutoutOpen),
  .controlPowerPresent(controlPowerPresent), .controlPowerLow(controlPowerLow),
  .contactorClosed(contactorClosed), .powerLamp(powerLamp), .alertLamp(alertLamp),
  .tripLamp(tripLamp)
);

//--- cdm_plant.sv
`timescale 1ns/1ps
module cdm_plant (
  input  wire mclk,
  input  wire coolDemand,
  input  wire contactorClosed,
  input  wire dead,
  input  wire slow,
  output wire lineSenseA,
  output wire lineSenseB,
  output wire lineSenseC
);
  // The contactor pulls in only when demand reaches its coil through the closed contact;
  // dead models a lost supply, slow a sluggish armature.
  reg  [1:0] pull;
  wire       live = slow ? pull[1] : pull[0];
  always @(posedge mclk)
  begin
    pull <= {pull[0], coolDemand & contactorClosed & !dead};
  end
  assign lineSenseA = live;
  assign lineSenseB = live;
  assign lineSenseC = live;
endmodule

//--- cdm_monitor_tb_top.sv
`timescale 1ns/1ps
module cdm_monitor_tb_top;
  localparam TICK = 10;
  localparam RCY  = 20;
  localparam QUAL = 3;
  localparam BLK  = 2;
  localparam PON  = 2;
  localparam POFF = 2;
  localparam PPS  = 5;
  localparam DLY  = RCY * TICK;
  // One full code group: every pulse on, the gaps between pulses, then the pause.
  localparam P2   = (2 * PON + POFF + PPS) * TICK;
  localparam P3   = (3 * PON + 2 * POFF + PPS) * TICK;
  logic mclk   = 1'b0;
  logic srst   = 1'b1;
  logic demand = 1'b0;
  logic lowCut = 1'b0;
  logic hiCut  = 1'b0;
  logic pwrOk  = 1'b1;
  logic pwrLow = 1'b0;
  logic dead   = 1'b0;
  logic slow   = 1'b0;
  int   n_fail = 0;
  int   samples_checked = 0;
  wire  sA, sB, sC, closed, green, yellow, red;

  initial
  begin
    forever #5 mclk = ~mclk;
  end

  cdm_monitor #(.TICK_CYCLES(TICK), .RECYCLE_MS(RCY), .TRIP_QUAL_MS(QUAL), .BLINK_MS(BLK),
    .ON_MS(PON), .OFF_MS(POFF), .PAUSE_MS(PPS)) uut (
    .mclk(mclk), .srst(srst), .coolDemand(demand), .lineSenseA(sA), .lineSenseB(sB),
    .lineSenseC(sC), .lowPressureCutoutOpen(lowCut), .highPressureCutoutOpen(hiCut),
    .controlPowerPresent(pwrOk), .controlPowerLow(pwrLow), .contactorClosed(closed),
    .powerLamp(green), .alertLamp(yellow), .tripLamp(red));

  cdm_plant plant (.mclk(mclk), .coolDemand(demand), .contactorClosed(closed), .dead(dead),
    .slow(slow), .lineSenseA(sA), .lineSenseB(sB), .lineSenseC(sC));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkn(input int got, input int exp);
    samples_checked++;
    if (got != exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic waitClosed(input int lim, output int took);
    took = 0;
    while (closed !== 1'b1 && took < lim)
    begin
      step(1);
      took++;
    end
    chk(closed, 1'b1);
    if (closed !== 1'b1)
      tally_and_finish();
  endtask

  // Counts yellow rises, red changes, yellow/red disagreements and closed cycles.
  task automatic watch(input int n, output int uy, output int fr, output int df, output int on);
    logic py;
    logic pr;
    uy = 0;
    fr = 0;
    df = 0;
    on = 0;
    py = yellow;
    pr = red;
    repeat (n)
    begin
      step(1);
      uy += (yellow === 1'b1 && py === 1'b0);
      fr += (red !== pr);
      df += (yellow !== red);
      on += (closed === 1'b1);
      py = yellow;
      pr = red;
    end
  endtask

  task automatic power_cycle;
    srst = 1'b1;
    step(5);
    chk(green, 1'b0);
    chk(closed, 1'b0);
    srst = 1'b0;
  endtask

  task automatic t_power_up;
    int uy, fr, df, on, took;
    watch(DLY - 10, uy, fr, df, on);
    chkn(on, 0);
    chk(fr >= 8, 1'b1);
    waitClosed(40, took);
    chk(red, 1'b0);
    chk(green, 1'b1);
  endtask

  task automatic t_rerun;
    int took;
    demand = 1'b1;
    step(DLY + 50);
    chk(closed, 1'b1);
    demand = 1'b0;
    step(10);
    chk(closed, 1'b0);
    demand = 1'b1;
    slow = 1'b1;
    step(DLY - 30);
    chk(closed, 1'b0);
    waitClosed(40, took);
    chk(took >= 20, 1'b1);
  endtask

  task automatic t_cutout;
    int uy, fr, df, on;
    hiCut = 1'b1;
    step(10);
    watch(2 * P2, uy, fr, df, on);
    chkn(uy, 4);
    chkn(on, 0);
    hiCut = 1'b0;
    step(10);
    chk(closed, 1'b1);
    watch(100, uy, fr, df, on);
    chkn(uy, 0);
    chk(red, 1'b0);
    lowCut = 1'b1;
    step(10);
    chk(closed, 1'b0);
    lowCut = 1'b0;
    step(10);
    chk(closed, 1'b1);
    demand = 1'b0;
    slow = 1'b0;
  endtask

  task automatic t_low_power;
    int uy, fr, df, on;
    pwrLow = 1'b1;
    step(10);
    watch(100, uy, fr, df, on);
    chkn(df, 0);
    chk(fr >= 4, 1'b1);
    pwrOk = 1'b0;
    step(10);
    chk(green, 1'b0);
    pwrLow = 1'b0;
    pwrOk = 1'b1;
  endtask

  task automatic t_short_cycle;
    int uy, fr, df, on, took;
    repeat (4)
    begin
      waitClosed(DLY + 50, took);
      demand = 1'b1;
      step(60);
      demand = 1'b0;
      step(10);
    end
    step(20);
    watch(2 * P3, uy, fr, df, on);
    chkn(uy, 6);
    chkn(on, 0);
    chkn(fr, 0);
    power_cycle();
    step(10);
    chk(yellow, 1'b0);
    waitClosed(DLY + 20, took);
  endtask

  task automatic t_trip;
    int uy, fr, df, on, took;
    dead = 1'b1;
    demand = 1'b1;
    step(80);
    chk(red, 1'b1);
    chk(closed, 1'b0);
    dead = 1'b0;
    watch(DLY + 50, uy, fr, df, on);
    chkn(fr, 0);
    chkn(on, 0);
    demand = 1'b0;
    power_cycle();
    waitClosed(DLY + 20, took);
    chk(red, 1'b0);
  endtask

  initial
  begin
    power_cycle();
    t_power_up();
    t_rerun();
    t_cutout();
    t_low_power();
    t_short_cycle();
    t_trip();
    tally_and_finish();
  end
endmodule
